/* tb_uart_with_baud_generator.sv */
`timescale 1ns/10ps
module tb_uart_with_baud_generator
  import uwbg_pkg::*;
;
  logic              pclk, presetn, ce, psel, penable, pwrite, t1_overflow;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic              pready, pslverr, irq, err;
  logic [1:0]        txd, shift_clk;
  wire  [1:0]        rxd;
  logic [8:0]        ch;
  int                n_mismatch, n_tests;

  uwbg_uart uwbg_uart_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .t1_overflow(t1_overflow), .rxd(rxd), .txd(txd),
    .shift_clk(shift_clk), .irq(irq));

  for (genvar g = 0; g < 2; g++) begin : node
    uwbg_remote_node uwbg_remote_node_i (
      .pclk(pclk), .line_in(txd[g]), .line_out(rxd[g]));
  end

  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd  = prdata;
    err = pslverr;
    if (n >= 20) n_mismatch++;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic t_reset;
    check(irq, 32'h0);
    check({txd, shift_clk}, 32'hF);
    apb(1'h0, OFF_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, {3'h0, OFF_CTRL}, 32'h0);
    check(rd, 32'(RESET_CTRL));
    // port 1 offset 1C is not mapped
    apb(1'h0, 8'h3C, 32'h0);
    check(err, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_tx8;
    apb(1'h1, {3'h0, OFF_RELOAD}, 32'h1);
    apb(1'h1, {3'h0, OFF_CTRL}, 32'h5);
    apb(1'h1, OFF_MASK, 32'h1);
    for (int e = 0; e < 3; e++) begin
      apb(1'h1, {3'h0, OFF_RATE}, 32'(e * 2 + 1));
      apb(1'h1, {3'h0, OFF_TX_DATA}, 32'hA5);
      node[0].uwbg_remote_node_i.recv(ch, 8, 32 << e);
      check(ch, 32'hA5);
      repeat (32 << e) @(posedge pclk);
    end
    check(irq, 32'h1);
    apb(1'h0, OFF_STATUS, 32'h0);
    check(rd, 32'h1);
    apb(1'h1, OFF_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    check(irq, 32'h0);
    apb(1'h1, OFF_STATUS, 32'h1);
    apb(1'h1, OFF_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    check(irq, 32'h0);
    $display("test transmit done");
  endtask

  task automatic t_rx;
    apb(1'h1, {3'h0, OFF_RATE}, 32'h1);
    node[0].uwbg_remote_node_i.send(9'h011, 8, 32);
    fork
      node[0].uwbg_remote_node_i.send(9'h022, 8, 32);
      begin
        repeat (100) @(posedge pclk);
        apb(1'h0, {3'h0, OFF_RX_DATA}, 32'h0);
      end
    join
    check(rd, 32'h211);
    apb(1'h0, {3'h0, OFF_RX_DATA}, 32'h0);
    check(rd, 32'h222);
    apb(1'h1, OFF_STATUS, 32'hFF);
    node[0].uwbg_remote_node_i.send(9'h033, 8, 32);
    node[0].uwbg_remote_node_i.send(9'h044, 8, 32);
    apb(1'h0, OFF_STATUS, 32'h0);
    check(rd, 32'h6);
    apb(1'h0, {3'h0, OFF_RX_DATA}, 32'h0);
    check(rd, 32'h233);
    $display("test receive done");
  endtask

  task automatic frame9(input logic [2:0] p, input logic [31:0] c,
                        input int per);
    apb(1'h1, {p, OFF_CTRL}, c);
    apb(1'h1, {p, OFF_TX_DATA}, 32'h15A);
    if (p == 3'h0) node[0].uwbg_remote_node_i.recv(ch, 9, per);
    else node[1].uwbg_remote_node_i.recv(ch, 9, per);
    check(ch, 32'h15A);
    repeat (per) @(posedge pclk);
  endtask

  task automatic t_mode2;
    frame9(3'h0, 32'hA, 32);
    frame9(3'h0, 32'h2, 64);
    frame9(3'h1, 32'hA, 64);
    frame9(3'h0, 32'h3, 32);
    $display("test nine bit done");
  endtask

  task automatic t_frac;
    apb(1'h1, {3'h0, OFF_CTRL}, 32'h1);
    apb(1'h1, {3'h0, OFF_RATE}, 32'h0);
    apb(1'h1, {3'h0, OFF_TX_DATA}, 32'h5A);
    repeat (100) @(posedge pclk);
    check(txd[0], 32'h0);
    apb(1'h1, {3'h0, OFF_RATE}, 32'h1);
    repeat (400) @(posedge pclk);
    apb(1'h1, {3'h0, OFF_DIV_INC}, 32'h80);
    apb(1'h1, {3'h0, OFF_DIV_CTRL}, 32'h1);
    apb(1'h1, {3'h0, OFF_TX_DATA}, 32'h5A);
    node[0].uwbg_remote_node_i.recv(ch, 8, 64);
    check(ch, 32'h5A);
    repeat (64) @(posedge pclk);
    apb(1'h1, {3'h0, OFF_DIV_INC}, 32'hF0);
    apb(1'h1, {3'h0, OFF_DIV_CTRL}, 32'h3);
    apb(1'h1, {3'h0, OFF_TX_DATA}, 32'h5A);
    repeat (300) @(posedge pclk);
    check(txd[0], 32'h0);
    apb(1'h0, {3'h0, OFF_DIV_CTRL}, 32'h0);
    check(rd, 32'h7);
    apb(1'h0, OFF_STATUS, 32'h0);
    check(rd & 32'h8, 32'h8);
    apb(1'h1, {3'h0, OFF_DIV_CTRL}, 32'h0);
    repeat (400) @(posedge pclk);
    $display("test divider done");
  endtask

  task automatic t_timer1;
    t1_overflow <= 1'h1;
    apb(1'h1, {3'h0, OFF_RATE}, 32'h0);
    frame9(3'h0, 32'h13, 32);
    t1_overflow <= 1'h0;
    $display("test timer one done");
  endtask

  task automatic t_mode0;
    for (int p = 0; p < 2; p++) begin
      apb(1'h1, {3'(p), OFF_CTRL}, 32'h0);
      apb(1'h1, {3'(p), OFF_TX_DATA}, 32'h96);
      ch = 9'h000;
      for (int i = 0; i < 8; i++) begin
        @(negedge shift_clk[0] or negedge shift_clk[1]);
        ch[i] = txd[p];
      end
      check(ch, 32'h96);
    end
    $display("test shift register done");
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    presetn     = 1'h0;
    ce          = 1'h1;
    psel        = 1'h0;
    penable     = 1'h0;
    pwrite      = 1'h0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    t1_overflow = 1'h0;
    n_mismatch  = 0;
    n_tests     = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset;
    t_tx8;
    t_rx;
    t_mode2;
    t_frac;
    t_timer1;
    t_mode0;
    print_verdict;
  end

  // the tests need some 9k clocks; this allows over four times that
  initial begin
    #2000000;
    n_mismatch++;
    print_verdict;
  end
endmodule // tb_uart_with_baud_generator

/* uwbg_pkg.sv */
// Function
// R1 - each port is full duplex, frames of 8 or 9 data bits, lsb first
// R2 - receiver takes a new character while the previous one is unread
// R3 - mode 0 is an 8-bit shift register clocked at pclk/2
// R4 - modes 1 and 3 send 8- and 9-bit frames at the variable rate
// R5 - mode 2 runs at pclk/32 or pclk/64; second port only pclk/64
// R6 - variable rate from timer underflows; first port may use timer 1
// R7 - each port owns prescaler, fractional divider and 8-bit reload timer
// R8 - timer counts down, clocked by divider when enabled, else prescaler
// R9 - fractional mode lets the run bit start and stop the timer
// R10 - on underflow the timer reloads and emits one pulse to the port
// R11 - divider enabled in normal mode stops the timer, run bit ignored
// R12 - prescaler divides pclk by two to the power of a 3-bit exponent
// R13 - fractional divider scales by increment over 256 only when active
// R14 - rate is pclk over 16, prescale and reload plus one
// R15 - bit rate never exceeds pclk/32; timer 1 with the fast bit ticks on every overflow, up to pclk/16
// R16 - interrupt requests on transmit done and receive done
// R17 - normal divider mode is an 8-bit auto-reload up-counter with flag
// R18 - fractional mode adds increment to accumulator, pulse on carry
package uwbg_pkg;

  localparam int          NUM_PORTS    = 2;
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          CHAR_W       = 9;

  // per-port window: paddr[7:5] selects the port, paddr[4:0] the register
  localparam logic [4:0]  OFF_CTRL     = 5'h00;
  localparam logic [4:0]  OFF_RATE     = 5'h04;
  localparam logic [4:0]  OFF_RELOAD   = 5'h08;
  localparam logic [4:0]  OFF_DIV_CTRL = 5'h0C;
  localparam logic [4:0]  OFF_DIV_INC  = 5'h10;
  localparam logic [4:0]  OFF_TX_DATA  = 5'h14;
  localparam logic [4:0]  OFF_RX_DATA  = 5'h18;
  localparam logic [7:0]  OFF_STATUS   = 8'h40;
  localparam logic [7:0]  OFF_MASK     = 8'h44;

  // control register fields
  localparam int          CTRL_MODE    = 0;
  localparam int          CTRL_REN     = 2;
  localparam int          CTRL_FAST    = 3;
  localparam int          CTRL_T1SEL   = 4;
  localparam int          CTRL_W       = 5;
  // rate control register fields
  localparam int          RATE_RUN     = 0;
  localparam int          RATE_PRE     = 1;
  // divider control register fields
  localparam int          DIV_EN       = 0;
  localparam int          DIV_MODE     = 1;
  localparam int          DIV_OVF      = 2;

  // status and mask layout, four bits per port
  localparam int          ST_TX        = 0;
  localparam int          ST_RX        = 1;
  localparam int          ST_LOST      = 2;
  localparam int          ST_OVF       = 3;
  localparam int          ST_W         = 4;

  localparam logic [CTRL_W-1:0] RESET_CTRL = 5'h00;
  localparam logic [7:0]  RESET_RELOAD = 8'h00;
  localparam logic [7:0]  RESET_INC    = 8'h00;

  // 16 ticks per bit; the middle tick samples the line
  localparam logic [3:0]  OS_LAST      = 4'hF;
  localparam logic [3:0]  OS_SAMPLE    = 4'h7;
  localparam logic [3:0]  BITS_MODE0   = 4'h8;
  localparam logic [3:0]  BITS_FRAME8  = 4'hA;
  localparam logic [3:0]  BITS_FRAME9  = 4'hB;
  localparam logic [3:0]  IDX_DATA8    = 4'h8;
  localparam logic [3:0]  IDX_DATA9    = 4'h9;

  typedef enum logic [1:0] {
    UWBG_SHIFT   = 2'h0,
    UWBG_UART8   = 2'h1,
    UWBG_UART9F  = 2'h2,
    UWBG_UART9V  = 2'h3
  } uwbg_mode_t;

  typedef enum logic [1:0] {
    UWBG_IDLE = 2'b01,
    UWBG_BUSY = 2'b10
  } uwbg_state_t;

endpackage

/* uwbg_remote_node.sv */
`timescale 1ns/10ps
module uwbg_remote_node (
  input  wire logic pclk,
  input  wire logic line_in,
  output logic      line_out
);
  initial line_out = 1'h1;

  task automatic send(input logic [8:0] d, input int n, input int per);
    line_out <= 1'h0;
    repeat (per) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      line_out <= d[i];
      repeat (per) @(posedge pclk);
    end
    line_out <= 1'h1;
    repeat (per) @(posedge pclk);
  endtask

  // mid-bit sampling; a bad start or stop bit inverts the result
  task automatic recv(output logic [8:0] d, input int n, input int per);
    logic ok;
    d = 9'h000;
    @(negedge line_in);
    repeat (per / 2) @(posedge pclk);
    ok = (line_in === 1'h0);
    for (int i = 0; i < n; i++) begin
      repeat (per) @(posedge pclk);
      d[i] = line_in;
    end
    repeat (per) @(posedge pclk);
    if (!ok || line_in !== 1'h1) d = ~d;
  endtask
endmodule // uwbg_remote_node

/* uwbg_uart.sv */
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module uwbg_uart
  import uwbg_pkg::*;
#(
  parameter int RELOAD_W = 8,
  parameter int PRE_W    = 3
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              t1_overflow,
  input  wire logic [1:0]        rxd,
  output logic      [1:0]        txd,
  output logic      [1:0]        shift_clk,
  output logic                   irq
);

  if (RELOAD_W != 8 || PRE_W != 3) begin : g_chk
    $error("uwbg_uart: only an 8-bit reload and 3-bit exponent are built");
  end

  localparam int PRE_CNT_W = 7;

  logic                        acc_go;
  logic                        wr_go;
  logic                        rd_go;
  logic [ST_W*NUM_PORTS-1:0]   events;
  logic [ST_W*NUM_PORTS-1:0]   status;
  logic [ST_W*NUM_PORTS-1:0]   mask;
  logic [DATA_W-1:0]           port_rd [NUM_PORTS];
  logic [NUM_PORTS-1:0]        port_ok;
  logic [DATA_W-1:0]           rd_word;
  logic                        rd_ok;

  // the transfer acts on the edge where the master sees pready high
  assign acc_go = psel & penable & pready;
  assign wr_go  = acc_go & pwrite;
  assign rd_go  = acc_go & ~pwrite;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [CTRL_W-1:0]     ctrl;
    logic                  run;
    logic [PRE_W-1:0]      pre_exp;
    logic [RELOAD_W-1:0]   reload_count;
    logic                  divider_enable;
    logic                  divider_mode_select;
    logic [7:0]            increment;
    logic                  rxd_s1;
    logic                  rxd_s2;
    logic [PRE_CNT_W-1:0]  pre_cnt;
    logic [7:0]            frac_acc;
    logic [7:0]            norm_cnt;
    logic [RELOAD_W-1:0]   rate_timer;
    logic                  uf_last;
    logic                  t1_half;
    logic [1:0]            m2_cnt;
    uwbg_state_t           tx_state;
    logic [10:0]           tx_sh;
    logic [3:0]            tx_bits;
    logic [3:0]            tx_os;
    logic                  m0_phase;
    logic                  txd_q;
    logic                  sclk_q;
    uwbg_state_t           rx_state;
    logic [3:0]            rx_os;
    logic [3:0]            rx_idx;
    logic [CHAR_W-1:0]     rx_sh;
    logic [CHAR_W-1:0]     rx_buf;
    logic                  rx_full;
    logic                  ev_tx;
    logic                  ev_rx;
    logic                  ev_lost;
    logic                  ev_ovf;
    uwbg_mode_t            mode;
    logic                  hit;
    logic [4:0]            loc;
    logic                  fast_ok;
    logic                  t1_ok;
    logic [PRE_CNT_W-1:0]  pre_mask;
    logic                  pre_tick;
    logic [8:0]            frac_sum;
    logic                  frac_tick;
    logic                  tmr_clk;
    logic                  tmr_run;
    logic                  uf_pulse;
    logic                  m2_tick;
    logic                  t1_tick;
    logic                  tick16;
    logic                  nine;
    logic                  m0_last;
    logic                  frame_end;
    logic                  rx_cmp;
    logic [CHAR_W-1:0]     rx_word;
    logic                  rx_clr;

    assign mode    = uwbg_mode_t'(ctrl[CTRL_MODE +: 2]);
    assign hit     = paddr[7:5] == 3'(p);
    assign loc     = paddr[4:0];
    // R5 second port fixed slow
    assign fast_ok = (p == 0) && ctrl[CTRL_FAST];
    assign t1_ok   = (p == 0) && ctrl[CTRL_T1SEL];
    assign nine    = mode != UWBG_UART8;

    // R12 prescale by power of two
    assign pre_mask  = PRE_CNT_W'(~({PRE_CNT_W{1'b1}} << pre_exp));
    assign pre_tick  = ce && ((pre_cnt & pre_mask) == pre_mask);
    // R18 accumulator carry pulses
    assign frac_sum  = {1'b0, frac_acc} + {1'b0, increment};
    // R13 scaling only when active
    assign frac_tick = pre_tick & frac_sum[8] & ~divider_mode_select;
    // R8 timer clock select
    assign tmr_clk   = divider_enable ? frac_tick : pre_tick;
    // R11 normal mode stops timer
    assign tmr_run   = run & ~(divider_enable & divider_mode_select);
    // R15 no back-to-back pulses
    assign uf_pulse  = tmr_run & tmr_clk & (rate_timer == '0) & ~uf_last;
    assign m2_tick   = ce && (fast_ok ? m2_cnt[0] : (m2_cnt == 2'h3));
    // timer 1 rate halved unless the fast bit doubles it
    assign t1_tick   = ce & t1_overflow & (ctrl[CTRL_FAST] | t1_half);
    // R4 R6 variable source select
    assign tick16    = (mode == UWBG_UART9F) ? m2_tick :
                       (t1_ok ? t1_tick : uf_pulse);

    assign m0_last   = (mode == UWBG_SHIFT) && tx_state == UWBG_BUSY &&
                       m0_phase && tx_bits == 4'h1 && ce;
    assign frame_end = ce && rx_state == UWBG_BUSY && tick16 &&
                       rx_os == OS_SAMPLE &&
                       rx_idx == (nine ? IDX_DATA9 : IDX_DATA8) + 4'h1;
    assign rx_cmp    = (m0_last & ctrl[CTRL_REN]) | frame_end;
    assign rx_word   = m0_last ? {1'b0, rxd_s2, rx_sh[8:2]} :
                       (nine ? rx_sh : {1'b0, rx_sh[8:1]});
    assign rx_clr    = rd_go & hit & (loc == OFF_RX_DATA);

    always_comb begin
      port_rd[p] = '0;
      port_ok[p] = 1'b1;
      unique case (loc)
        OFF_CTRL:     port_rd[p] = DATA_W'(ctrl);
        OFF_RATE:     port_rd[p] = DATA_W'({pre_exp, run});
        OFF_RELOAD:   port_rd[p] = DATA_W'(reload_count);
        OFF_DIV_CTRL: port_rd[p] = DATA_W'({status[p*ST_W+ST_OVF],
                                     divider_mode_select, divider_enable});
        OFF_DIV_INC:  port_rd[p] = DATA_W'(increment);
        OFF_TX_DATA:  port_rd[p] = DATA_W'(tx_state == UWBG_BUSY);
        OFF_RX_DATA:  port_rd[p] = DATA_W'({rx_full, rx_buf});
        default:      port_ok[p] = 1'b0;
      endcase
    end

    // software-written settings
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctrl                <= RESET_CTRL;
        run                 <= 1'b0;
        pre_exp             <= '0;
        reload_count        <= RESET_RELOAD;
        divider_enable      <= 1'b0;
        divider_mode_select <= 1'b0;
        increment           <= RESET_INC;
      end else if (ce && wr_go && hit) begin
        if (loc == OFF_CTRL) begin
          ctrl <= pwdata[CTRL_W-1:0];
        end
        if (loc == OFF_RATE) begin
          // R9 run bit starts timer
          run     <= pwdata[RATE_RUN];
          pre_exp <= pwdata[RATE_PRE +: PRE_W];
        end
        if (loc == OFF_RELOAD) begin
          reload_count <= pwdata[RELOAD_W-1:0];
        end
        if (loc == OFF_DIV_CTRL) begin
          divider_enable      <= pwdata[DIV_EN];
          divider_mode_select <= pwdata[DIV_MODE];
        end
        if (loc == OFF_DIV_INC) begin
          increment <= pwdata[7:0];
        end
      end
    end

    // rx pin is asynchronous to pclk
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rxd_s1 <= 1'b1;
        rxd_s2 <= 1'b1;
      end else if (ce) begin
        rxd_s1 <= rxd[p];
        rxd_s2 <= rxd_s1;
      end
    end

    // R7 per-port rate generator
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pre_cnt    <= '0;
        frac_acc   <= '0;
        norm_cnt   <= '0;
        rate_timer <= '0;
        uf_last    <= 1'b0;
        t1_half    <= 1'b0;
        m2_cnt     <= '0;
        ev_ovf     <= 1'b0;
      end else if (ce) begin
        pre_cnt <= pre_cnt + PRE_CNT_W'(1);
        m2_cnt  <= m2_cnt + 2'h1;
        uf_last <= uf_pulse;
        ev_ovf  <= 1'b0;
        if (t1_overflow) begin
          t1_half <= ~t1_half;
        end
        if (pre_tick && divider_enable && !divider_mode_select) begin
          frac_acc <= frac_sum[7:0];
        end
        // R17 auto-reload up-counter
        if (pre_tick && divider_enable && divider_mode_select) begin
          if (norm_cnt == 8'hFF) begin
            norm_cnt <= increment;
            ev_ovf   <= 1'b1;
          end else begin
            norm_cnt <= norm_cnt + 8'h01;
          end
        end
        // R10 R14 reload on underflow
        if (tmr_run && tmr_clk) begin
          if (rate_timer == '0) begin
            rate_timer <= reload_count;
          end else begin
            rate_timer <= rate_timer - RELOAD_W'(1);
          end
        end
      end
    end

    // transmitter
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tx_state <= UWBG_IDLE;
        tx_sh    <= '1;
        tx_bits  <= '0;
        tx_os    <= '0;
        m0_phase <= 1'b0;
        txd_q    <= 1'b1;
        sclk_q   <= 1'b1;
        ev_tx    <= 1'b0;
      end else if (ce) begin
        ev_tx <= 1'b0;
        unique case (tx_state)
          UWBG_IDLE: begin
            sclk_q <= 1'b1;
            if (wr_go && hit && loc == OFF_TX_DATA) begin
              tx_state <= UWBG_BUSY;
              tx_os    <= '0;
              m0_phase <= 1'b0;
              // R3 shift register load
              if (mode == UWBG_SHIFT) begin
                tx_sh   <= {3'b111, pwdata[7:0]};
                tx_bits <= BITS_MODE0;
                txd_q   <= pwdata[0];
              // R1 start, data lsb first, stop
              end else if (nine) begin
                tx_sh   <= {1'b1, pwdata[8:0], 1'b0};
                tx_bits <= BITS_FRAME9;
                txd_q   <= 1'b0;
              end else begin
                tx_sh   <= {2'b11, pwdata[7:0], 1'b0};
                tx_bits <= BITS_FRAME8;
                txd_q   <= 1'b0;
              end
            end
          end
          UWBG_BUSY: begin
            if (mode == UWBG_SHIFT) begin
              // R3 two pclk per bit
              m0_phase <= ~m0_phase;
              sclk_q   <= m0_phase;
              if (m0_phase) begin
                tx_sh   <= {1'b1, tx_sh[10:1]};
                tx_bits <= tx_bits - 4'h1;
                txd_q   <= tx_sh[1];
              end
            end else if (tick16) begin
              tx_os <= tx_os + 4'h1;
              if (tx_os == OS_LAST) begin
                tx_sh   <= {1'b1, tx_sh[10:1]};
                tx_bits <= tx_bits - 4'h1;
                txd_q   <= tx_sh[1];
              end
            end
            if ((mode == UWBG_SHIFT && m0_phase && tx_bits == 4'h1) ||
                (mode != UWBG_SHIFT && tick16 && tx_os == OS_LAST &&
                 tx_bits == 4'h1)) begin
              tx_state <= UWBG_IDLE;
              txd_q    <= 1'b1;
              sclk_q   <= 1'b1;
              // R16 transmit done
              ev_tx    <= 1'b1;
            end
          end
        endcase
      end
    end

    // receiver
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rx_state <= UWBG_IDLE;
        rx_os    <= '0;
        rx_idx   <= '0;
        rx_sh    <= '0;
        rx_buf   <= '0;
        rx_full  <= 1'b0;
        ev_rx    <= 1'b0;
        ev_lost  <= 1'b0;
      end else if (ce) begin
        ev_rx   <= 1'b0;
        ev_lost <= 1'b0;
        if (mode == UWBG_SHIFT) begin
          rx_state <= UWBG_IDLE;
          if (tx_state == UWBG_BUSY && m0_phase) begin
            rx_sh <= {rxd_s2, rx_sh[8:1]};
          end
        end else begin
          unique case (rx_state)
            UWBG_IDLE: begin
              if (ctrl[CTRL_REN] && !rxd_s2) begin
                rx_state <= UWBG_BUSY;
                rx_os    <= '0;
                rx_idx   <= '0;
              end
            end
            UWBG_BUSY: begin
              if (tick16) begin
                rx_os <= rx_os + 4'h1;
                if (rx_os == OS_SAMPLE) begin
                  rx_idx <= rx_idx + 4'h1;
                  if (rx_idx == 4'h0 && rxd_s2) begin
                    // glitch, not a start bit
                    rx_state <= UWBG_IDLE;
                  end else if (frame_end) begin
                    rx_state <= UWBG_IDLE;
                  end else if (rx_idx != 4'h0) begin
                    rx_sh <= {rxd_s2, rx_sh[8:1]};
                  end
                end
              end
            end
          endcase
        end
        // a completion in the same cycle as the read still lands
        if (rx_clr) begin
          rx_full <= 1'b0;
        end
        // R2 second character while unread
        if (rx_cmp) begin
          if (rx_full && !rx_clr) begin
            // the newer character is the one dropped
            ev_lost <= 1'b1;
          end else begin
            rx_buf  <= rx_word;
            rx_full <= 1'b1;
            // R16 receive done
            ev_rx   <= 1'b1;
          end
        end
      end
    end

    assign events[p*ST_W +: ST_W] = {ev_ovf, ev_lost, ev_rx, ev_tx};

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        txd[p]       <= 1'b1;
        shift_clk[p] <= 1'b1;
      end else if (ce) begin
        txd[p]       <= txd_q;
        shift_clk[p] <= sclk_q;
      end
    end
  end

  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b0;
    if (paddr[7:5] < 3'(NUM_PORTS)) begin
      rd_word = port_rd[paddr[5]];
      rd_ok   = port_ok[paddr[5]];
    end else if (paddr == OFF_STATUS) begin
      rd_word = DATA_W'(status);
      rd_ok   = 1'b1;
    end else if (paddr == OFF_MASK) begin
      rd_word = DATA_W'(mask);
      rd_ok   = 1'b1;
    end
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        prdata  <= pwrite ? '0 : rd_word;
        pslverr <= ~rd_ok;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= '0;
    end else if (ce && wr_go && paddr == OFF_MASK) begin
      mask <= pwdata[ST_W*NUM_PORTS-1:0];
    end
  end

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else if (ce) begin
      if (wr_go && paddr == OFF_STATUS) begin
        status <= (status & ~pwdata[ST_W*NUM_PORTS-1:0]) | events;
      end else begin
        status <= status | events;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(status & mask);
    end
  end

endmodule // uwbg_uart

/* uwbg_uart_checker.sv */
`timescale 1ns/10ps
module uwbg_uart_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  txd,
  input wire logic [1:0]  shift_clk,
  input wire logic        irq
);
  logic [5:0] run_len;
  logic       txd_q;
  logic       clk_seen;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // run length of txd[0]; mode-0 clocking voids a run, its bits are short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_len  <= 6'h00;
      txd_q    <= 1'h1;
      clk_seen <= 1'h1;
    end else begin
      txd_q <= txd[0];
      if (txd[0] != txd_q) begin
        run_len  <= 6'h01;
        clk_seen <= !shift_clk[0];
      end else begin
        if (run_len != 6'h3F) run_len <= run_len + 6'h01;
        if (!shift_clk[0]) clk_seen <= 1'h1;
      end
    end
  end

  chk_ready_wait: assert property (
    ce && psel && penable && !pready |=> pready)
    else $error("pready not given after one wait state");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_ready_cause: assert property (
    pready |-> psel && penable && $past(penable))
    else $error("pready outside an access phase");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("prdata not zero on write");
  chk_reset_idle: assert property ($rose(presetn) |->
    txd == 2'h3 && shift_clk == 2'h3 && !irq && !pready)
    else $error("outputs not idle after reset");
  chk_shift_low0: assert property (
    $fell(shift_clk[0]) |=> shift_clk[0])
    else $error("port 0 shift clock low too long");
  chk_shift_low1: assert property (
    $fell(shift_clk[1]) |=> shift_clk[1])
    else $error("port 1 shift clock low too long");
  chk_bit_length: assert property (
    txd[0] != txd_q && !clk_seen |-> run_len >= 6'h1F)
    else $error("serial bit shorter than 32 clocks");
endmodule // uwbg_uart_checker

bind uwbg_uart uwbg_uart_checker uwbg_uart_checker_i (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .txd(txd), .shift_clk(shift_clk), .irq(irq));
